// ---- fmm_pkg.sv ----
// Shared constants and operation codes for the floating-point move/multiply unit.
// Assumes one 200 MHz core clock and a synchronous active-low reset.
package fmm_pkg;
   localparam logic [1:0]        RM_NEAREST   = 2'h0;
   localparam logic [1:0]        RM_PLUS      = 2'h1;
   localparam logic [1:0]        RM_MINUS     = 2'h2;
   localparam logic [1:0]        RM_ZERO      = 2'h3;
   localparam int                RMODE_LSB    = 22;
   localparam int                FLAGS_LSB    = 28;
   localparam logic [31:0]       STATUS_RESET = 32'h0;
   localparam logic [31:0]       DEFAULT_NAN  = 32'h7fc00000;
   localparam logic [30:0]       INF_MAG      = 31'h7f800000;
   localparam logic [30:0]       MAX_FINITE   = 31'h7f7fffff;
   localparam logic signed [9:0] EXP_BIAS     = 10'sh07f;
   localparam logic signed [9:0] EXP_MAX      = 10'sh0ff;
   localparam logic [31:0]       WORD_BYTES   = 32'h4;
   localparam logic [3:0]        SP_IDX       = 4'hd;
   localparam logic [4:0]        POP_MAX      = 5'h10;
   localparam logic [5:0]        ONE_WORD     = 6'h1;
   localparam real               CLK_NS       = 5.0;

   typedef enum logic [3:0] {
      OP_LOAD, OP_POP, OP_MAC, OP_MSUB, OP_MUL, OP_NMLA, OP_NMLS, OP_NMUL,
      OP_NEG, OP_MOVIMM, OP_MOVREG, OP_XFER_SINGLE, OP_XFER_HALF, OP_XFER_PAIR,
      OP_STAT_RD, OP_STAT_WR
   } fmm_op_type;

   typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_MEM, ST_SECOND} fmm_state_type;
endpackage

// ---- fmm_fp_regfile.sv ----
// Extension register file: one write port, three registered read ports.
// Assumes the caller never reads a word in the same cycle it writes it.
`timescale 1ns/1ps
module fmm_fp_regfile import fmm_pkg::*; #(
   parameter int DEPTH = 32,
   parameter int AW    = 5
) (
   // Clock and reset
   input  logic          core_clk,
   input  logic          nrst,
   // Write port
   input  logic          we,
   input  logic [AW-1:0] waddr,
   input  logic [31:0]   wdata,
   // Read ports
   input  logic [AW-1:0] raddrA,
   input  logic [AW-1:0] raddrB,
   input  logic [AW-1:0] raddrC,
   output logic [31:0]   rdataA,
   output logic [31:0]   rdataB,
   output logic [31:0]   rdataC
);
   logic [31:0] mem [DEPTH];

   // No reset on the array itself, only on the read registers
   always_ff @(posedge core_clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         rdataA <= 32'h0;
         rdataB <= 32'h0;
         rdataC <= 32'h0;
      end else begin
         rdataA <= mem[raddrA];
         rdataB <= mem[raddrB];
         rdataC <= mem[raddrC];
      end
   end
endmodule

// ---- fmm_core.sv ----
// Floating-point move/multiply unit: loads, pops, moves, status transfers, multiply family.
// Assumes the integer core supplies register values and flags; memory answers with memAck.
//
// How it works
// RULE1 - Load address is base plus signed word offset
// RULE2 - Load fetches one register, base may be PC
// RULE3 - Double size writes double, single writes single
// RULE4 - Multiply-accumulate adds product to destination
// RULE5 - Multiply-subtract takes product from destination
// RULE6 - Immediate move expands constant into register
// RULE7 - Register move copies double or single whole
// RULE8 - Half index picks low or high word
// RULE9 - Core word written into selected half
// RULE10 - Core partner never names PC or SP
// RULE11 - Single transfer copies word unchanged either way
// RULE12 - Pair transfer uses adjacent floating registers
// RULE13 - Status read copies status into core register
// RULE14 - Flag form copies status flags to core flags
// RULE15 - Status write loads status from core register
// RULE16 - Multiply writes product to destination
// RULE17 - Negate inverts only the sign bit
// RULE18 - Negated add: minus destination minus product
// RULE19 - Negated subtract: minus destination plus product
// RULE20 - Negated multiply writes minus product
// RULE21 - Partner gives consistent pop size and list
// RULE22 - Pop loads one to sixteen consecutive registers
// RULE23 - Failed condition changes no state
// RULE24 - Arithmetic rounds by status rounding mode
`timescale 1ns/1ps
module fmm_core import fmm_pkg::*; (
   // Clock and reset
   input  logic        core_clk,
   input  logic        nrst,
   // Operation request
   input  logic        opValid,
   output logic        opReady,
   input  fmm_op_type  opCode,
   input  logic [3:0]  condCode,
   input  logic [3:0]  coreFlags,
   input  logic [4:0]  destIdx,
   input  logic [4:0]  srcFirstIdx,
   input  logic [4:0]  srcSecondIdx,
   input  logic        isDouble,
   input  logic        halfSel,
   input  logic        toCore,
   input  logic        flagDest,
   input  logic        baseIsPc,
   input  logic [7:0]  immConst,
   input  logic [7:0]  offsetWords,
   input  logic        offsetAdd,
   input  logic [4:0]  popCount,
   input  logic [3:0]  coreTransferIdx,
   input  logic [3:0]  secondCoreTransferIdx,
   input  logic [31:0] coreData,
   input  logic [31:0] coreData2,
   // Core register and flag writes
   output logic        coreWrValid,
   output logic [3:0]  coreWrIdx,
   output logic [31:0] coreWrData,
   output logic        coreWr2Valid,
   output logic [3:0]  coreWr2Idx,
   output logic [31:0] coreWr2Data,
   output logic        flagWrValid,
   output logic [3:0]  flagsOut,
   // Memory read
   output logic        memReq,
   output logic [31:0] memAddr,
   input  logic        memAck,
   input  logic [31:0] memData,
   // Status/control
   output logic [31:0] fpStatus
);
   function automatic logic condPass(input logic [3:0] c, input logic [3:0] f);
      logic r;
      unique case (c[3:1])
         3'h0: r = f[2];
         3'h1: r = f[1];
         3'h2: r = f[3];
         3'h3: r = f[0];
         3'h4: r = f[1] & !f[2];
         3'h5: r = f[3] == f[0];
         3'h6: r = !f[2] & (f[3] == f[0]);
         3'h7: r = 1'b1;
      endcase
      return r ^ (c[0] & (c[3:1] != 3'h7));
   endfunction

   function automatic logic [31:0] fpExpandImm(input logic [7:0] i);
      return {i[7], ~i[6], {5{i[6]}}, i[5:4], i[3:0], 19'h0};
   endfunction

   // Subnormal results flush to zero: area traded for full gradual underflow
   function automatic logic [31:0] fpPack(input logic s, input logic signed [9:0] e, input logic [23:0] sig,
                                          input logic g, input logic st, input logic [1:0] rm);
      logic             up;
      logic [24:0]      sum;
      logic signed [9:0] ex;
      up = (rm == RM_NEAREST) ? (g & (st | sig[0])) :
           (rm == RM_PLUS) ? (!s & (g | st)) :
           (rm == RM_MINUS) ? (s & (g | st)) : 1'b0;
      sum = {1'b0, sig} + {24'h0, up};
      ex = sum[24] ? e + 10'sd1 : e;
      if (ex >= EXP_MAX) begin
         return (rm == RM_ZERO || (rm == RM_PLUS && s) || (rm == RM_MINUS && !s)) ?
                {s, MAX_FINITE} : {s, INF_MAG};
      end
      if (ex <= 10'sd0) begin
         return {s, 31'h0};
      end
      return {s, ex[7:0], sum[24] ? sum[23:1] : sum[22:0]};
   endfunction

   function automatic logic [31:0] fpMul(input logic [31:0] a, input logic [31:0] b, input logic [1:0] rm);
      logic             s;
      logic             aN, bN, aI, bI, aZ, bZ;
      logic [47:0]      p;
      logic signed [9:0] e;
      s  = a[31] ^ b[31];
      aN = a[30:23] == 8'hff && a[22:0] != 23'h0;
      bN = b[30:23] == 8'hff && b[22:0] != 23'h0;
      aI = a[30:23] == 8'hff && a[22:0] == 23'h0;
      bI = b[30:23] == 8'hff && b[22:0] == 23'h0;
      aZ = a[30:23] == 8'h0;
      bZ = b[30:23] == 8'h0;
      p  = {24'h0, 1'b1, a[22:0]} * {24'h0, 1'b1, b[22:0]};
      e  = $signed({2'b00, a[30:23]}) + $signed({2'b00, b[30:23]}) - EXP_BIAS;
      if (aN | bN | (aI & bZ) | (aZ & bI)) return DEFAULT_NAN;
      if (aI | bI) return {s, INF_MAG};
      if (aZ | bZ) return {s, 31'h0};
      if (p[47]) return fpPack(s, e + 10'sd1, p[47:24], p[23], |p[22:0], rm);
      return fpPack(s, e, p[46:23], p[22], |p[21:0], rm);
   endfunction

   function automatic logic [31:0] fpAdd(input logic [31:0] a, input logic [31:0] b, input logic [1:0] rm);
      logic [31:0]      x, y;
      logic [26:0]      mx, my, lost;
      logic [27:0]      sum;
      logic [7:0]       d8;
      logic signed [9:0] e;
      x = a;
      y = b;
      mx = 27'h0;
      my = 27'h0;
      lost = 27'h0;
      sum = 28'h0;
      d8 = 8'h0;
      e = 10'sd0;
      if ((a[30:23] == 8'hff && a[22:0] != 23'h0) || (b[30:23] == 8'hff && b[22:0] != 23'h0)) return DEFAULT_NAN;
      if (a[30:0] == INF_MAG && b[30:0] == INF_MAG && a[31] != b[31]) return DEFAULT_NAN;
      if (a[30:0] == INF_MAG) return a;
      if (b[30:0] == INF_MAG) return b;
      if (a[30:23] == 8'h0 && b[30:23] == 8'h0) return {(a[31] & b[31]) | (rm == RM_MINUS && (a[31] | b[31])), 31'h0};
      if (a[30:23] == 8'h0) return b;
      if (b[30:23] == 8'h0) return a;
      if (a[30:0] < b[30:0]) begin
         x = b;
         y = a;
      end
      mx = {1'b1, x[22:0], 3'h0};
      my = {1'b1, y[22:0], 3'h0};
      d8 = x[30:23] - y[30:23];
      if (d8 > 8'd26) begin
         lost = my;
         my = 27'h0;
      end else begin
         lost = my & ((27'h1 << d8) - 27'h1);
         my = my >> d8;
      end
      my[0] = my[0] | (|lost);
      e = $signed({2'b00, x[30:23]});
      sum = (x[31] ^ y[31]) ? {1'b0, mx} - {1'b0, my} : {1'b0, mx} + {1'b0, my};
      if (sum == 28'h0) return {rm == RM_MINUS, 31'h0};
      if (sum[27]) begin
         sum = {1'b0, sum[27:2], sum[1] | sum[0]};
         e = e + 10'sd1;
      end else begin
         for (int k = 0; k < 26; k++) begin
            if (!sum[26]) begin
               sum = sum << 1;
               e = e - 10'sd1;
            end
         end
      end
      return fpPack(x[31], e, sum[26:3], sum[2], |sum[1:0], rm);
   endfunction

   fmm_state_type state;
   fmm_op_type    op;
   logic [4:0]    dIdx, wIdx, hiIdx;
   logic          dbl, half, toC, flagD, popSp;
   logic [7:0]    imm;
   logic [3:0]    cIdx, cIdx2;
   logic [31:0]   cData, cData2, hiData;
   logic [5:0]    wordsLeft;
   logic [31:0]   rdA, rdB, rdC;

   // Request decode
   wire         accept    = opValid && state == ST_IDLE;
   wire         condOk    = condPass(condCode, coreFlags);
   wire         popOk     = popCount != 5'h0 && popCount <= POP_MAX;
   wire         go        = accept && condOk && (opCode != OP_POP || popOk);  // [RULE23] [RULE22]
   wire         isXfer    = opCode == OP_XFER_SINGLE || opCode == OP_XFER_PAIR;
   wire [31:0]  baseAddr  = baseIsPc ? {coreData[31:2], 2'b00} : coreData;  // [RULE2]
   wire [31:0]  offBytes  = {22'h0, offsetWords, 2'b00};
   wire [31:0]  loadAddr  = offsetAdd ? baseAddr + offBytes : baseAddr - offBytes;  // [RULE1]
   wire [5:0]   baseWords = (opCode == OP_POP) ? {1'b0, popCount} : ONE_WORD;  // [RULE21]
   wire [5:0]   wordCount = isDouble ? {baseWords[4:0], 1'b0} : baseWords;  // [RULE3]
   wire [4:0]   firstIdx  = isDouble ? {destIdx[3:0], 1'b0} : destIdx;

   // Read addresses are only meaningful in the accept cycle
   wire [4:0] rdAddrA = (opCode == OP_XFER_HALF) ? {destIdx[3:0], halfSel} :  // [RULE8]
                        isXfer ? destIdx :
                        (opCode == OP_MOVREG) ? (isDouble ? {srcSecondIdx[3:0], 1'b0} : srcSecondIdx) :
                        srcFirstIdx;
   wire [4:0] rdAddrB = (opCode == OP_XFER_PAIR) ? destIdx + 5'h1 :  // [RULE12]
                        (opCode == OP_MOVREG && isDouble) ? {srcSecondIdx[3:0], 1'b1} : srcSecondIdx;

   // Arithmetic datapath
   wire [1:0]  rmode   = fpStatus[RMODE_LSB +: 2];  // [RULE24]
   wire [31:0] prod    = fpMul(rdA, rdB, rmode);
   wire [31:0] negProd = {~prod[31], prod[30:0]};
   wire [31:0] negDest = {~rdC[31], rdC[30:0]};
   wire [31:0] arithRes = (op == OP_MAC) ? fpAdd(rdC, prod, rmode) :  // [RULE4]
                          (op == OP_MSUB) ? fpAdd(rdC, negProd, rmode) :  // [RULE5]
                          (op == OP_NMLA) ? fpAdd(negDest, negProd, rmode) :  // [RULE18]
                          (op == OP_NMLS) ? fpAdd(negDest, prod, rmode) :  // [RULE19]
                          (op == OP_NMUL) ? negProd : prod;  // [RULE20] [RULE16]
   wire isArith = op == OP_MAC || op == OP_MSUB || op == OP_MUL || op == OP_NMLA || op == OP_NMLS || op == OP_NMUL;
   wire isFromCore = (op == OP_XFER_SINGLE || op == OP_XFER_HALF || op == OP_XFER_PAIR) && !toC;

   // Register file write selection
   wire execWe = state == ST_EXEC && (isArith || isFromCore || op == OP_NEG || op == OP_MOVIMM || op == OP_MOVREG);
   wire memWe  = state == ST_MEM && memAck;
   wire rfWe   = execWe || memWe || state == ST_SECOND;
   wire [4:0] execAddr = (op == OP_XFER_HALF) ? {dIdx[3:0], half} :  // [RULE9]
                         (op == OP_MOVREG && dbl) ? {dIdx[3:0], 1'b0} : dIdx;
   wire [31:0] execData = isArith ? arithRes :
                          (op == OP_NEG) ? {~rdB[31], rdB[30:0]} :  // [RULE17]
                          (op == OP_MOVIMM) ? fpExpandImm(imm) :  // [RULE6]
                          (op == OP_MOVREG) ? rdA : cData;  // [RULE7] [RULE11]
   wire [4:0]  rfWaddr = memWe ? wIdx : (state == ST_SECOND) ? hiIdx : execAddr;
   wire [31:0] rfWdata = memWe ? memData : (state == ST_SECOND) ? hiData : execData;

   assign opReady = state == ST_IDLE;

   fmm_fp_regfile #(
      .DEPTH (32),
      .AW    (5)
   ) u_regs (
      .core_clk (core_clk),
      .nrst     (nrst),
      .we       (rfWe),
      .waddr    (rfWaddr),
      .wdata    (rfWdata),
      .raddrA   (rdAddrA),
      .raddrB   (rdAddrB),
      .raddrC   (destIdx),
      .rdataA   (rdA),
      .rdataB   (rdB),
      .rdataC   (rdC)
   );

   // Request latch
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         // Enum kept out of the packed group so it only ever takes legal codes
         op <= OP_LOAD;
         {dIdx, dbl, half, toC, flagD, imm, cIdx, cIdx2, cData, cData2} <= '0;
      end else if (go) begin
         op <= opCode;
         {dIdx, dbl, half, toC, flagD} <= {destIdx, isDouble, halfSel, toCore, flagDest};
         {imm, cIdx, cIdx2, cData, cData2} <= {immConst, coreTransferIdx, secondCoreTransferIdx, coreData, coreData2};
      end
   end

   // Sequencer
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         state <= ST_IDLE;
         {coreWrValid, coreWrIdx, coreWrData, coreWr2Valid, coreWr2Idx, coreWr2Data} <= '0;
         {flagWrValid, flagsOut, memReq, memAddr, wIdx, wordsLeft, popSp, hiIdx, hiData} <= '0;
         fpStatus <= STATUS_RESET;
      end else begin
         coreWrValid  <= 1'b0;
         coreWr2Valid <= 1'b0;
         flagWrValid  <= 1'b0;
         unique case (state)
            ST_IDLE: begin
               if (go) begin
                  state     <= ST_EXEC;
                  memAddr   <= (opCode == OP_POP) ? coreData : loadAddr;
                  wIdx      <= firstIdx;
                  wordsLeft <= wordCount;
                  popSp     <= opCode == OP_POP;
               end
            end
            ST_EXEC: begin
               state <= ST_IDLE;
               if (op == OP_LOAD || op == OP_POP) begin
                  memReq <= 1'b1;
                  state  <= ST_MEM;
               end
               if (op == OP_MOVREG && dbl) begin
                  {hiIdx, hiData} <= {dIdx[3:0], 1'b1, rdB};
                  state           <= ST_SECOND;
               end
               if (op == OP_XFER_PAIR && !toC) begin
                  {hiIdx, hiData} <= {dIdx + 5'h1, cData2};  // [RULE12]
                  state           <= ST_SECOND;
               end
               // Core index trusted to be neither PC nor SP
               if ((op == OP_XFER_SINGLE || op == OP_XFER_HALF || op == OP_XFER_PAIR) && toC) begin  // [RULE10]
                  {coreWrValid, coreWrIdx, coreWrData} <= {1'b1, cIdx, rdA};  // [RULE11] [RULE8]
               end
               if (op == OP_XFER_PAIR && toC) begin
                  {coreWr2Valid, coreWr2Idx, coreWr2Data} <= {1'b1, cIdx2, rdB};  // [RULE12]
               end
               if (op == OP_STAT_RD && flagD) begin
                  {flagWrValid, flagsOut} <= {1'b1, fpStatus[FLAGS_LSB +: 4]};  // [RULE14]
               end
               if (op == OP_STAT_RD && !flagD) begin
                  {coreWrValid, coreWrIdx, coreWrData} <= {1'b1, cIdx, fpStatus};  // [RULE13]
               end
               if (op == OP_STAT_WR) begin
                  fpStatus <= cData;  // [RULE15]
               end
            end
            ST_MEM: begin
               if (memAck) begin
                  wIdx      <= wIdx + 5'h1;
                  wordsLeft <= wordsLeft - ONE_WORD;
                  memAddr   <= memAddr + WORD_BYTES;  // [RULE22]
                  if (wordsLeft == ONE_WORD) begin
                     memReq <= 1'b0;
                     state  <= ST_IDLE;
                     // Stack pointer written back once the last word lands
                     if (popSp) begin
                        {coreWrValid, coreWrIdx, coreWrData} <= {1'b1, SP_IDX, memAddr + WORD_BYTES};
                     end
                  end
               end
            end
            ST_SECOND: state <= ST_IDLE;
         endcase
      end
   end

   property p_condBlock;
      @(posedge core_clk) disable iff (!nrst) accept && !condOk |=> state == ST_IDLE && !rfWe;
   endproperty
   a_condBlock: assert property (p_condBlock) else $error("failed condition changed state");  // [RULE23]

   property p_loadAddr;
      @(posedge core_clk) disable iff (!nrst)
         go && opCode == OP_LOAD |-> ##2 memReq && memAddr == $past(loadAddr, 2);
   endproperty
   a_loadAddr: assert property (p_loadAddr) else $error("load address wrong");  // [RULE1]

   property p_loadSize;
      @(posedge core_clk) disable iff (!nrst)
         go && opCode == OP_LOAD |=> wordsLeft == ($past(isDouble) ? 6'h2 : 6'h1) && wIdx == $past(firstIdx);
   endproperty
   a_loadSize: assert property (p_loadSize) else $error("load size wrong");  // [RULE3]

   property p_halfRead;
      @(posedge core_clk) disable iff (!nrst)
         go && opCode == OP_XFER_HALF && toCore |-> rdAddrA == {destIdx[3:0], halfSel} ##2 coreWrValid;
   endproperty
   a_halfRead: assert property (p_halfRead) else $error("half read wrong");  // [RULE8]

   property p_halfWrite;
      @(posedge core_clk) disable iff (!nrst)
         go && opCode == OP_XFER_HALF && !toCore |->
            ##1 rfWe && rfWaddr == $past({destIdx[3:0], halfSel}) && rfWdata == $past(coreData);
   endproperty
   a_halfWrite: assert property (p_halfWrite) else $error("half write wrong");  // [RULE9]

   property p_negSign;
      @(posedge core_clk) disable iff (!nrst)
         go && opCode == OP_NEG |-> ##1 rfWe && rfWaddr == $past(destIdx) && rfWdata == (rdB ^ 32'h80000000);
   endproperty
   a_negSign: assert property (p_negSign) else $error("negate wrong");  // [RULE17]

   property p_statWrite;
      @(posedge core_clk) disable iff (!nrst) go && opCode == OP_STAT_WR |-> ##2 fpStatus == $past(coreData, 2);
   endproperty
   a_statWrite: assert property (p_statWrite) else $error("status write wrong");  // [RULE15]

   property p_statFlags;
      @(posedge core_clk) disable iff (!nrst)
         go && opCode == OP_STAT_RD && flagDest |-> ##2 flagWrValid && !coreWrValid && flagsOut == fpStatus[31:28];
   endproperty
   a_statFlags: assert property (p_statFlags) else $error("flag transfer wrong");  // [RULE14]

   property p_immMove;
      @(posedge core_clk) disable iff (!nrst)
         go && opCode == OP_MOVIMM |-> ##1 rfWe && rfWdata == fpExpandImm($past(immConst));
   endproperty
   a_immMove: assert property (p_immMove) else $error("immediate move wrong");  // [RULE6]
endmodule

// ---- fmm_mem_model.sv ----
// Memory model answering the unit's word reads, promptly or slowly.
// Assumes the unit takes memAck at the rising edge after it is raised.
`timescale 1ns/1ps
module fmm_mem_model (
   // Clock
   input  logic        core_clk,
   // Read request
   input  logic        memReq,
   input  logic [31:0] memAddr,
   input  logic        slow,
   // Answer
   output logic        memAck,
   output logic [31:0] memData
);
   int waitCnt = 0;

   initial begin
      memAck  = 1'b0;
      memData = 32'h0;
   end

   // Data toggles when idle so a stale word never looks valid
   always @(posedge core_clk) begin
      memData <= ~memData;
      if (memAck) begin
         memAck <= 1'b0;
      end else if (memReq && waitCnt == 0) begin
         memAck  <= 1'b1;
         memData <= {memAddr[15:0], ~memAddr[15:0]};
         waitCnt <= slow ? 3 : 0;
      end else if (memReq) begin
         waitCnt <= waitCnt - 1;
      end
   end
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the move/multiply unit with a memory model.
// Assumes completion is shown by opReady returning high.
`timescale 1ns/1ps
module tb_top import fmm_pkg::*; ;
   logic        core_clk, nrst, opValid, opReady, isDouble, halfSel, toCore, flagDest, baseIsPc;
   logic        offsetAdd, coreWrValid, coreWr2Valid, flagWrValid, memReq, memAck, slow, reqQ;
   logic [3:0]  condCode, coreFlags, coreTransferIdx, secondCoreTransferIdx, coreWrIdx, coreWr2Idx, flagsOut;
   logic [4:0]  destIdx, srcFirstIdx, srcSecondIdx, popCount;
   logic [7:0]  immConst, offsetWords;
   logic [31:0] coreData, coreData2, coreWrData, coreWr2Data, memAddr, memData, fpStatus, firstAddr, v, b, e;
   fmm_op_type  opCode;
   int          errors = 0, n_compared = 0, nWr = 0, nFl = 0;
   fmm_op_type  ops[6] = '{OP_MUL, OP_MAC, OP_MSUB, OP_NMLA, OP_NMLS, OP_NMUL};
   logic [31:0] exps[6] = '{32'h40c00000, 32'h40e00000, 32'hc0a00000, 32'hc0e00000, 32'h40a00000, 32'hc0c00000};

   fmm_core dut (.core_clk, .nrst, .opValid, .opReady, .opCode, .condCode, .coreFlags, .destIdx, .srcFirstIdx,
      .srcSecondIdx, .isDouble, .halfSel, .toCore, .flagDest, .baseIsPc, .immConst, .offsetWords, .offsetAdd,
      .popCount, .coreTransferIdx, .secondCoreTransferIdx, .coreData, .coreData2, .coreWrValid, .coreWrIdx,
      .coreWrData, .coreWr2Valid, .coreWr2Idx, .coreWr2Data, .flagWrValid, .flagsOut, .memReq, .memAddr,
      .memAck, .memData, .fpStatus);
   fmm_mem_model mem (.core_clk, .memReq, .memAddr, .slow, .memAck, .memData);

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   // First address of each burst and a count of core writes
   always @(posedge core_clk) begin
      reqQ <= memReq;
      if (memReq && !reqQ) firstAddr <= memAddr;
      if (coreWrValid === 1'b1) nWr <= nWr + 1;
      if (flagWrValid === 1'b1) nFl <= nFl + 1;
   end

   function automatic logic [31:0] imm_f(input logic [7:0] i);
      return {i[7], ~i[6], {5{i[6]}}, i[5:0], 19'h0};
   endfunction

   function automatic logic [31:0] word_f(input logic [31:0] a);
      return {a[15:0], ~a[15:0]};
   endfunction

   task automatic complete_run();
      $display("errors %0d compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic issue(input fmm_op_type c, input logic [4:0] d, input logic [4:0] s);
      int n;
      @(posedge core_clk);
      opCode       <= c;
      destIdx      <= d;
      srcSecondIdx <= s;
      opValid      <= 1'b1;
      @(posedge core_clk);
      opValid <= 1'b0;
      n = 0;
      do begin
         @(posedge core_clk);
         #1;
         n++;
      end while (opReady !== 1'b1 && n < 60);
      chk("ready", 32'h1, {31'h0, opReady});
      if (opReady !== 1'b1) complete_run();
      repeat (2) @(posedge core_clk);
      #1;
   endtask

   task automatic wr(input logic [4:0] d, input logic [31:0] val);
      toCore   <= 1'b0;
      coreData <= val;
      issue(OP_XFER_SINGLE, d, 0);
   endtask

   task automatic rd(input logic [4:0] d, input logic [31:0] exp, input string nm);
      toCore          <= 1'b1;
      coreTransferIdx <= 4'(d % 5'd13);
      issue(OP_XFER_SINGLE, d, 0);
      chk(nm, exp, coreWrData);
   endtask

   initial begin
      {opValid, isDouble, halfSel, toCore, flagDest, baseIsPc, offsetAdd, slow, reqQ} = 0;
      {coreFlags, coreTransferIdx, secondCoreTransferIdx, destIdx, srcFirstIdx, srcSecondIdx} = 0;
      {immConst, offsetWords, popCount, coreData, coreData2} = 0;
      condCode = 4'he;
      opCode   = OP_MUL;
      nrst     = 1'b0;
      v = $urandom(32'h1f47);
      repeat (4) @(posedge core_clk);
      nrst <= 1'b1;
      #1;
      chk("status reset", STATUS_RESET, fpStatus);
      for (int i = 0; i < 4; i++) begin
         v = $urandom;
         b = 32'($urandom_range(31));
         wr(b[4:0], v);
         rd(b[4:0], v, "single xfer");
         issue(OP_NEG, 5'(b + 1), b[4:0]);
         rd(5'(b + 1), v ^ 32'h80000000, "negate");
         issue(OP_MOVREG, 5'(b + 2), 5'(b + 1));
         rd(5'(b + 2), v ^ 32'h80000000, "move");
      end
      wr(1, 32'h40000000);
      wr(2, 32'h40400000);
      srcFirstIdx <= 5'h1;
      foreach (ops[i]) begin
         wr(3, 32'h3f800000);
         issue(ops[i], 3, 2);
         rd(3, exps[i], "arith");
      end
      for (int i = 0; i < 3; i++) begin
         v = $urandom;
         immConst <= v[7:0];
         issue(OP_MOVIMM, 4, 0);
         rd(4, imm_f(v[7:0]), "immediate");
      end
      // Equal test fails with zero flag clear, not-equal passes
      b = nWr;
      immConst <= ~v[7:0];
      condCode <= 4'h0;
      issue(OP_MOVIMM, 4, 0);
      chk("skipped write", b, nWr);
      condCode <= 4'he;
      rd(4, imm_f(v[7:0]), "skipped move");
      condCode <= 4'h1;
      issue(OP_MOVIMM, 4, 0);
      condCode <= 4'he;
      rd(4, imm_f(~v[7:0]), "passed move");
      for (int h = 0; h < 2; h++) begin
         e = b;
         b = $urandom;
         coreData <= b;
         halfSel  <= h[0];
         toCore   <= 1'b0;
         issue(OP_XFER_HALF, 3, 0);
         rd(5'(6 + h), b, "half write");
         issue(OP_XFER_HALF, 3, 0);
         chk("half read", b, coreWrData);
      end
      isDouble <= 1'b1;
      issue(OP_MOVREG, 5, 3);
      isDouble <= 1'b0;
      rd(10, e, "double move low");
      rd(11, b, "double move high");
      v = $urandom;
      b = $urandom;
      coreData  <= v;
      coreData2 <= b;
      toCore    <= 1'b0;
      issue(OP_XFER_PAIR, 14, 0);
      toCore                <= 1'b1;
      coreTransferIdx       <= 4'h9;
      secondCoreTransferIdx <= 4'h2;
      issue(OP_XFER_PAIR, 14, 0);
      chk("pair first", v, coreWrData);
      chk("pair second", b, coreWr2Data);
      chk("pair index", 32'h2, {28'h0, coreWr2Idx});
      rd(15, b, "pair adjacent");
      for (int k = 0; k < 4; k++) begin
         v = $urandom;
         b = $urandom;
         if (k == 3) b[7:0] = 8'hff;
         e = (k[1] ? v & ~32'h3 : v) + (b[8] ? 32'(b[7:0]) * 4 : -(32'(b[7:0]) * 4));
         coreData    <= v;
         offsetWords <= b[7:0];
         offsetAdd   <= b[8];
         isDouble    <= k[0];
         baseIsPc    <= k[1];
         slow        <= k[1];
         issue(OP_LOAD, 5'(8 + k), 0);
         isDouble <= 1'b0;
         chk("load address", e, firstAddr);
         rd(k[0] ? 5'(16 + 2 * k) : 5'(8 + k), word_f(e), "load low");
         if (k[0]) rd(5'(17 + 2 * k), word_f(e + 4), "load high");
      end
      v = $urandom & ~32'h3;
      coreData <= v;
      popCount <= 5'h3;
      issue(OP_POP, 20, 0);
      chk("pop sp index", 32'hd, {28'h0, coreWrIdx});
      chk("pop sp value", v + 12, coreWrData);
      rd(22, word_f(v + 8), "pop last");
      b = nWr;
      popCount <= 5'h0;
      issue(OP_POP, 20, 0);
      chk("empty pop", b, nWr);
      v = $urandom;
      coreData <= v;
      issue(OP_STAT_WR, 0, 0);
      chk("status write", v, fpStatus);
      coreTransferIdx <= 4'he;
      issue(OP_STAT_RD, 0, 0);
      chk("status read", v, coreWrData);
      chk("status index", 32'he, {28'h0, coreWrIdx});
      flagDest <= 1'b1;
      issue(OP_STAT_RD, 0, 0);
      chk("flags", 32'(v[31:28]), 32'(flagsOut));
      chk("flag strobe", 32'h1, nFl);
      complete_run();
   end
endmodule
